//--- dmcp_host.sv
// host master model driving the control port pins
`timescale 1ns/1ps
`default_nettype none
module dmcp_host (
	// clock and sensed data line
	input  wire logic clk_sys,
	input  wire logic sda_line,
	// pins driven by the host
	output var logic  scl,
	output var logic  sda,
	output var logic  sel_b
);
	// ****
	// pin timing
	// ****
	initial begin
		scl   = 1'b1;
		sda   = 1'b1;
		sel_b = 1'b1;
	end
	// quarter of the 64 ns serial clock
	task automatic q;
		repeat (4) @(posedge clk_sys);
	endtask : q
	task automatic bit_x(input logic b, output logic r);
		sda <= b;
		q();
		scl <= 1'b1;
		q();
		r = sda_line;
		q();
		scl <= 1'b0;
		q();
	endtask : bit_x
	task automatic start;
		sda <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask : start
	task automatic stop;
		sda <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda <= 1'b1;
		q();
	endtask : stop
	// mack high releases the line: write bytes or final nack
	task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(tx[i], rx[i]);
		bit_x(mack, ack);
	endtask : byte_x
	task automatic spi(input logic [39:0] w);
		scl   <= 1'b0;
		sel_b <= 1'b0;
		q();
		for (int i = 39; i >= 0; i--) begin
			sda <= w[i];
			q();
			scl <= 1'b1;
			q();
			q();
			scl <= 1'b0;
			q();
		end
		sel_b <= 1'b1;
		q();
		// line no longer held: do not leave the last bit
		sda <= ~w[0];
	endtask : spi
endmodule : dmcp_host
`default_nettype wire

//--- dmcp_pkg.sv
// package for the dual mode control port: constants and carrier types
package dmcp_pkg;

	localparam logic [6:0] DMCP_ADDR_BASE    = 7'h0A;
	localparam int         DMCP_ADDR_SEL_BIT = 5;
	localparam logic [6:0] DMCP_ADDR_FIXED   = 7'h0A;
	localparam int         DMCP_SPI_BITS     = 32;
	localparam logic [15:0] DMCP_ADDR_RESET  = 16'h0000;
	localparam logic [3:0] DMCP_BIT_LAST     = 4'h8;
	localparam logic [2:0] DMCP_SYNC_RESET   = 3'h7;
	localparam logic [1:0] DMCP_STRAP_WAIT   = 2'h2;

	// register access request handed to the register file
	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [15:0] data;
	} dmcp_req_type;

	typedef enum logic [2:0] {
		DMCP_IDLE,
		DMCP_DEVADDR,
		DMCP_ACK,
		DMCP_RXBYTE,
		DMCP_TXBYTE,
		DMCP_RXACK
	} dmcp_state_type;

endpackage : dmcp_pkg

//--- dmcp_port.sv
// dual mode control port: i2c slave or write-only spi slave
// Function
// - mode strap low selects i2c slave, high selects spi slave
// - large package answers i2c address 0n01010, n from address pin
// - small package answers fixed i2c address 0001010 only
// - device is always slave and never drives the serial clock
// - register addresses and data are both sixteen bits wide
// - i2c read: address written first, then read returns two bytes high first
// - device acks address and written bytes; master nacks final read byte
// - access address increments after every completed data byte pair
// - any start or stop ends the command in progress
// - a read without new address starts at current address, keeps incrementing
// - spi uses address pin as select, clock pin as sclk, data pin as mosi
// - spi mode writes registers only, never drives serial output
// - select rising latches last 32 bits: address high, value low
`timescale 1ns/1ps
`default_nettype none
module dmcp_port
	import dmcp_pkg::*;
#(
	parameter bit LARGE_PKG = 1'b1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// straps and pins
	input  wire logic         mode_spi_strap,
	input  wire logic         addr_bit_chip_select_input,
	input  wire logic         ctrl_clk_in,
	input  wire logic         ctrl_data_in,
	output logic              ctrl_data_out,
	output logic              ctrl_data_oe,
	// register file side
	output dmcp_req_type      reg_req,
	input  wire logic [15:0]  reg_rdata
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= DMCP_SYNC_RESET;
			sync2 <= DMCP_SYNC_RESET;
			sync3 <= DMCP_SYNC_RESET;
		end else begin
			sync1 <= {addr_bit_chip_select_input, ctrl_clk_in, ctrl_data_in};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	wire logic sel_now  = sync2[2];
	wire logic clk_now  = sync2[1];
	wire logic dat_now  = sync2[0];
	wire logic clk_rise = clk_now && !sync3[1];
	wire logic clk_fall = !clk_now && sync3[1];
	wire logic sel_rise = sel_now && !sync3[2];
	// start and stop: data moves while clock is high
	wire logic i2c_start = clk_now && sync3[1] && !dat_now && sync3[0];
	wire logic i2c_stop  = clk_now && sync3[1] && dat_now && !sync3[0];

	// ************************************************************
	// strap capture after reset release
	// ************************************************************
	// strap is only sampled once, so mid-run toggling cannot break a frame
	// capture waits until both synchroniser stages hold real pin levels
	logic [1:0] mode_sync;
	logic [1:0] strap_wait;
	logic       strap_done;
	logic       spi_mode;
	logic       addr_n;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_sync  <= 2'h0;
			strap_wait <= 2'h0;
			strap_done <= 1'b0;
			spi_mode   <= 1'b0;
			addr_n     <= 1'b0;
		end else begin
			mode_sync <= {mode_sync[0], mode_spi_strap};
			if (!strap_done && strap_wait == DMCP_STRAP_WAIT) begin
				strap_done <= 1'b1;
				spi_mode   <= mode_sync[1];
				addr_n     <= sel_now;
			end else if (!strap_done) begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	wire logic [6:0] own_addr = LARGE_PKG ?
		(DMCP_ADDR_BASE | (7'(addr_n) << DMCP_ADDR_SEL_BIT)) : DMCP_ADDR_FIXED;
	wire logic i2c_on = strap_done && !spi_mode;
	wire logic spi_on = strap_done && spi_mode;

	// ************************************************************
	// spi shift path
	// ************************************************************
	logic [DMCP_SPI_BITS-1:0] spi_shift;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spi_shift <= '0;
		end else if (spi_on && !sel_now && clk_rise) begin
			spi_shift <= {spi_shift[DMCP_SPI_BITS-2:0], dat_now};
		end
	end
	wire logic spi_commit = spi_on && sel_rise;

	// ************************************************************
	// i2c state machine
	// ************************************************************
	dmcp_state_type state;
	dmcp_state_type next_state;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic        rw_read;
	logic [1:0]  byte_idx;   // 0,1 address bytes; 2,3 data bytes
	logic [15:0] acc_addr;
	logic [7:0]  data_hi;
	logic [7:0]  data_lo;
	logic        wr_due;     // low data byte taken, write waits for its ack
	logic        tx_lo;
	logic        ack_drive;

	wire logic       byte_done = clk_rise && (bitcnt == DMCP_BIT_LAST - 4'h1);
	wire logic [7:0] rx_byte   = {shreg[6:0], dat_now};
	wire logic       addr_hit  = rx_byte[7:1] == own_addr;
	wire logic [7:0] tx_byte   = tx_lo ? reg_rdata[7:0] : reg_rdata[15:8];
	wire logic       i2c_wr    = (state == DMCP_ACK) && clk_fall && bitcnt == DMCP_BIT_LAST
		&& wr_due;

	always_comb begin
		next_state = state;
		case (state)
			DMCP_IDLE:    next_state = DMCP_IDLE;
			DMCP_DEVADDR: if (byte_done) next_state = addr_hit ? DMCP_ACK : DMCP_IDLE;
			DMCP_ACK:     if (clk_fall && bitcnt == DMCP_BIT_LAST)
				next_state = rw_read ? DMCP_TXBYTE : DMCP_RXBYTE;
			DMCP_RXBYTE:  if (byte_done) next_state = DMCP_ACK;
			DMCP_TXBYTE:  if (byte_done) next_state = DMCP_RXACK;
			DMCP_RXACK:   if (clk_rise) next_state = dat_now ? DMCP_IDLE : DMCP_TXBYTE;
			default:      next_state = DMCP_IDLE;
		endcase
		if (!i2c_on) next_state = DMCP_IDLE;
		else if (i2c_start) next_state = DMCP_DEVADDR;
		else if (i2c_stop) next_state = DMCP_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= DMCP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bitcnt  <= 4'h0;
			shreg   <= 8'h00;
			rw_read <= 1'b0;
		end else if (i2c_start || next_state != state) begin
			bitcnt <= 4'h0;
			if (state == DMCP_DEVADDR && byte_done) rw_read <= dat_now;
			if (state == DMCP_RXACK) bitcnt <= 4'h0;
		end else if (clk_rise && state == DMCP_ACK) begin
			bitcnt <= DMCP_BIT_LAST;
		end else if (clk_rise && bitcnt != DMCP_BIT_LAST) begin
			bitcnt <= bitcnt + 4'h1;
			shreg  <= rx_byte;
		end
	end

	// ack cycle counts its own rising edge: bitcnt reaches last on it
	// byte bookkeeping, address and auto increment
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			byte_idx <= 2'd0;
			acc_addr <= DMCP_ADDR_RESET;
			data_hi  <= 8'h00;
			data_lo  <= 8'h00;
			wr_due   <= 1'b0;
			tx_lo    <= 1'b0;
		end else if (i2c_start) begin
			byte_idx <= 2'd0;
			wr_due   <= 1'b0;
			tx_lo    <= 1'b0;
		end else if (state == DMCP_RXBYTE && byte_done) begin
			case (byte_idx)
				2'd0: acc_addr[15:8] <= rx_byte;
				2'd1: acc_addr[7:0]  <= rx_byte;
				2'd2: data_hi        <= rx_byte;
				default: data_lo     <= rx_byte;
			endcase
			byte_idx <= (byte_idx == 2'd3) ? 2'd2 : byte_idx + 2'd1;
			wr_due   <= byte_idx == 2'd3;
		end else if (i2c_wr) begin
			wr_due   <= 1'b0;
			acc_addr <= acc_addr + 16'h0001;
		end else if (state == DMCP_TXBYTE && byte_done) begin
			tx_lo <= !tx_lo;
			if (tx_lo) acc_addr <= acc_addr + 16'h0001;
		end
	end

	// ************************************************************
	// data pin drive and register requests
	// ************************************************************
	// open drain: only pull low, never drive the clock pin
	wire logic drive_low = (state == DMCP_ACK && bitcnt != DMCP_BIT_LAST && !clk_rise
		&& (!clk_now || ack_drive))
		|| (state == DMCP_TXBYTE && !tx_byte[3'(7 - bitcnt)]);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_drive     <= 1'b0;
			ctrl_data_out <= 1'b0;
			ctrl_data_oe  <= 1'b0;
			reg_req       <= '0;
		end else begin
			ack_drive     <= state == DMCP_ACK && !clk_now;
			ctrl_data_out <= 1'b0;
			ctrl_data_oe  <= i2c_on && clk_now == 1'b0 ? drive_low : (ctrl_data_oe && !clk_fall
				&& state != DMCP_IDLE);
			reg_req.write <= i2c_wr || spi_commit;
			reg_req.read  <= state == DMCP_TXBYTE;
			reg_req.addr  <= spi_commit ? spi_shift[31:16] : acc_addr;
			reg_req.data  <= spi_commit ? spi_shift[15:0] : {data_hi, data_lo};
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_spi_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
		spi_on |-> !ctrl_data_oe) else $error("data driven in spi mode");
	a_stop_ends_cmd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(i2c_on && i2c_stop && !i2c_start) |=> state == DMCP_IDLE)
		else $error("stop did not end command");
	a_spi_latch_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		spi_commit |=> reg_req.write && reg_req.addr == $past(spi_shift[31:16])
		&& reg_req.data == $past(spi_shift[15:0])) else $error("spi word not latched");
	a_addr_miss: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == DMCP_DEVADDR && byte_done && !addr_hit && !i2c_start) |=> state == DMCP_IDLE)
		else $error("foreign address accepted");
	a_wr_incr_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		i2c_wr |=> acc_addr == $past(acc_addr) + 16'h0001) else $error("no increment");
	a_wr_req_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		i2c_wr |=> reg_req.write ##1 !reg_req.write) else $error("write request wrong");
	a_start_restart: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(i2c_on && i2c_start) |=> state == DMCP_DEVADDR && byte_idx == 2'd0)
		else $error("start did not restart");
	a_mode_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
		strap_done |=> $stable(spi_mode)) else $error("mode changed");

	// ************************************************************
	// handshake checks
	// ************************************************************
	// ack bit: held low through the high phase, released on the fall
	sequence s_ack_low;
		state == DMCP_ACK && !clk_now && bitcnt != DMCP_BIT_LAST;
	endsequence

	sequence s_ack_end;
		state == DMCP_ACK && clk_fall && bitcnt == DMCP_BIT_LAST;
	endsequence

	sequence s_addr_match;
		state == DMCP_DEVADDR && byte_done && addr_hit;
	endsequence

	a_ack_pull_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_ack_low |=> ctrl_data_oe) else $error("ack not driven");

	a_ack_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == DMCP_ACK && clk_rise) |=> bitcnt == DMCP_BIT_LAST)
		else $error("ack clock not counted");

	a_ack_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_ack_end |=> !ctrl_data_oe && state != DMCP_ACK) else $error("ack not released");

	a_own_addr_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_addr_match |=> state == DMCP_ACK) else $error("own address not acked");

	a_nack_ends: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == DMCP_RXACK && clk_rise && dat_now) |=> state == DMCP_IDLE)
		else $error("nack did not end read");

	// read side only moves on after the low byte has gone out
	a_rd_incr_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == DMCP_TXBYTE && byte_done && tx_lo) |=> acc_addr == $past(acc_addr) + 16'h0001)
		else $error("read address not incremented");

	a_wr_req_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
		i2c_wr |=> reg_req.addr == $past(acc_addr) && reg_req.data == {$past(data_hi),
		$past(data_lo)}) else $error("write word wrong");

	a_spi_no_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		spi_on |-> !reg_req.read) else $error("read request in spi mode");

endmodule : dmcp_port
`default_nettype wire

//--- testbench.sv
// self-checking bench for the dual mode control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dmcp_pkg::*;
	logic         clk_sys;
	logic         rst_b;
	logic         strap;
	logic         n_bit;
	logic         oe;
	logic         dout;
	logic         oe_seen;
	logic         rd_seen;
	logic [7:0]   rx;
	logic         ack;
	dmcp_req_type req;
	logic [31:0]  wq[$];
	int           mismatches;
	int           n_tests;
	wire logic    scl;
	wire logic    sda_h;
	wire logic    sel_b;
	// pull-up line, device only pulls low
	wire logic    sda_line = sda_h & ~oe;
	wire logic    pin_a    = strap ? sel_b : n_bit;
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	dmcp_port #(.LARGE_PKG(1'b1)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.mode_spi_strap(strap), .addr_bit_chip_select_input(pin_a), .ctrl_clk_in(scl),
		.ctrl_data_in(sda_line), .ctrl_data_out(dout), .ctrl_data_oe(oe), .reg_req(req),
		.reg_rdata(req.addr ^ 16'hF0F0));
	dmcp_host u_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda_h),
		.sel_b(sel_b));
	always @(posedge clk_sys) begin
		if (req.write === 1'b1)
			wq.push_back({req.addr, req.data});
		if (oe === 1'b1)
			oe_seen <= 1'b1;
		if (req.read === 1'b1)
			rd_seen <= 1'b1;
	end
	// ****
	// helpers
	// ****
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic reset_dut(input logic spi);
		rst_b <= 1'b0;
		strap <= spi;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : reset_dut
	task automatic wr(input logic [7:0] b);
		u_host.byte_x(b, 1'b1, rx, ack);
		check("ack", ack, 0);
	endtask : wr
	task automatic rd(input logic last, input logic [7:0] exp);
		u_host.byte_x(8'hFF, last, rx, ack);
		check("read byte", rx, exp);
	endtask : rd
	// ****
	// scenarios
	// ****
	task automatic t_write;
		logic [7:0] b[6] = '{8'h12, 8'h34, 8'hA5, 8'hC3, 8'h5A, 8'h3C};
		wq.delete();
		u_host.start();
		wr(8'h54);
		foreach (b[i])
			wr(b[i]);
		u_host.stop();
		repeat (8) @(posedge clk_sys);
		check("writes", wq.size(), 2);
		check("first", wq[0], 32'h1234A5C3);
		check("second", wq[1], 32'h12355A3C);
	endtask : t_write
	task automatic t_foreign;
		wq.delete();
		u_host.start();
		u_host.byte_x(8'h14, 1'b1, rx, ack);
		check("foreign ack", ack, 1);
		u_host.byte_x(8'h00, 1'b1, rx, ack);
		u_host.stop();
		check("foreign writes", wq.size(), 0);
	endtask : t_foreign
	task automatic t_read;
		u_host.start();
		wr(8'h54);
		wr(8'h00);
		wr(8'h40);
		u_host.start();
		wr(8'h55);
		rd(1'b0, 8'hF0);
		rd(1'b0, 8'hB0);
		rd(1'b0, 8'hF0);
		rd(1'b1, 8'hB1);
		u_host.stop();
		u_host.start();
		wr(8'h55);
		rd(1'b0, 8'hF0);
		rd(1'b1, 8'hB2);
		u_host.stop();
		check("read req", rd_seen, 1);
	endtask : t_read
	task automatic t_spi;
		reset_dut(1'b1);
		wq.delete();
		oe_seen = 1'b0;
		rd_seen = 1'b0;
		u_host.spi(40'hFF_BEEF_1357);
		repeat (8) @(posedge clk_sys);
		check("spi writes", wq.size(), 1);
		check("spi word", wq[0], 32'hBEEF1357);
		check("spi oe", oe_seen, 0);
		check("spi read", rd_seen, 0);
		check("data out", dout, 0);
	endtask : t_spi
	initial begin
		rst_b      = 1'b0;
		strap      = 1'b0;
		n_bit      = 1'b1;
		oe_seen    = 1'b0;
		rd_seen    = 1'b0;
		mismatches = 0;
		n_tests    = 0;
		reset_dut(1'b0);
		t_write();
		t_foreign();
		t_read();
		t_spi();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
